// ---- sdc_defs.svh ----
// Purpose: Constants for the synchronous DRAM command front end
// Assumes: 25 MHz system clock, 4 banks, 32-bit data in four byte lanes
// Notes:   Offsets, fields, reset values and timing counts live here
//
// How it works
// - Row on 11 address bits, column on 8
// - Precharge address bit 10 selects all banks
// - Bank select picks bank for activate/access
// - Chip select high ignores commands, operations continue
// - Row, column, write strobes decode the command
// - Read mask floats byte two cycles later
// - Write mask blocks byte write immediately
// - Clock enable low enters low-power states
// - Mode register undefined until first programmed; here reset loads 11'h000 with mode_valid_o low
// - All strobes low loads mode register
// - Column access: write select low writes
// - Burst stop: only chip, write select low
// - Address bit 10 on access requests auto-precharge
`ifndef SDC_DEFS_SVH
`define SDC_DEFS_SVH

`define SDC_ROW_W          11
`define SDC_COL_W          8
`define SDC_BANK_W         2
`define SDC_NUM_BANKS      4
`define SDC_BYTES          4
`define SDC_AP_BIT         10
`define SDC_MASK_LAT       2
`define SDC_MODE_RST       11'h000
`define SDC_INIT_REFRESH   4'h8
`define SDC_BURST_LEN      4
`define SDC_CLK_MHZ        25
`define SDC_INIT_PAUSE_US  200
`define SDC_INIT_PAUSE_CYC (`SDC_INIT_PAUSE_US * `SDC_CLK_MHZ)

`endif

// ---- sdc_pkg.sv ----
// Purpose: Types shared by the command front end
// Assumes: sdc_defs.svh supplies the widths
// Notes:   None
`include "sdc_defs.svh"

package sdc_pkg;

  typedef enum logic [3:0] {
    SDC_DESEL,
    SDC_NOP,
    SDC_MRS,
    SDC_REFRESH,
    SDC_PRECHARGE,
    SDC_ACTIVATE,
    SDC_WRITE,
    SDC_READ,
    SDC_BSTOP
  } sdc_cmd_t;

  typedef enum logic [1:0] {
    SDC_PWR_ACTIVE,
    SDC_PWR_DOWN,
    SDC_PWR_SUSPEND,
    SDC_PWR_SELF_REF
  } sdc_pwr_t;

  typedef struct packed {
    logic                     cs_n;
    logic                     ras_n;
    logic                     cas_n;
    logic                     we_n;
    logic [`SDC_BANK_W-1:0]   bank_sel;
    logic [`SDC_ROW_W-1:0]    addr;
  } sdc_pins_t;

  typedef struct packed {
    sdc_cmd_t                 cmd;
    logic [`SDC_BANK_W-1:0]   bank;
    logic [`SDC_ROW_W-1:0]    row;
    logic [`SDC_COL_W-1:0]    col;
    logic                     auto_pre;
    logic                     pre_all;
  } sdc_op_t;

endpackage

// ---- sdc_cmd_decode.sv ----
// Purpose: Combinational command decoder for the sampled command pins
// Assumes: Pins are synchronous to the system clock
// Notes:   Output is meaningful only at the sampling edge
`timescale 1ns/1ps
`include "sdc_defs.svh"

module sdc_cmd_decode (
  input  wire sdc_pkg::sdc_pins_t pins_i,
  output sdc_pkg::sdc_cmd_t       cmd_o
);

  always_comb begin
    if (pins_i.cs_n) begin
      cmd_o = sdc_pkg::SDC_DESEL;
    end else begin
      case ({pins_i.ras_n, pins_i.cas_n, pins_i.we_n})
        3'h0:    cmd_o = sdc_pkg::SDC_MRS;
        3'h1:    cmd_o = sdc_pkg::SDC_REFRESH;
        3'h2:    cmd_o = sdc_pkg::SDC_PRECHARGE;
        3'h3:    cmd_o = sdc_pkg::SDC_ACTIVATE;
        3'h4:    cmd_o = sdc_pkg::SDC_WRITE;
        3'h5:    cmd_o = sdc_pkg::SDC_READ;
        3'h6:    cmd_o = sdc_pkg::SDC_BSTOP;
        default: cmd_o = sdc_pkg::SDC_NOP;
      endcase
    end
  end

endmodule // sdc_cmd_decode

// ---- sdc_front.sv ----
// Purpose: Command front end: decode, bank state, byte masks, power states, init
// Assumes: All pins synchronous to clk_i; burst length is a parameter
// Notes:   Data path itself is outside; byte enables steer it
`timescale 1ns/1ps
`include "sdc_defs.svh"

module sdc_front #(
  parameter int unsigned BURST_LEN      = `SDC_BURST_LEN,
  parameter int unsigned INIT_PAUSE_CYC = `SDC_INIT_PAUSE_CYC
) (
  input  wire logic                      clk_i,
  input  wire logic                      reset_i,
  input  wire logic                      cke_i,
  input  wire sdc_pkg::sdc_pins_t        pins_i,
  input  wire logic [`SDC_BYTES-1:0]     byte_mask_i,
  output sdc_pkg::sdc_op_t               op_o,
  output logic [`SDC_NUM_BANKS-1:0]      bank_active_o,
  output logic [`SDC_ROW_W-1:0]          mode_reg_o,
  output logic                           mode_valid_o,
  output sdc_pkg::sdc_pwr_t              pwr_state_o,
  output logic                           rd_busy_o,
  output logic                           wr_busy_o,
  output logic [`SDC_BYTES-1:0]          dq_oe_n_o,
  output logic [`SDC_BYTES-1:0]          wr_byte_en_o,
  output logic                           init_done_o
);

  localparam int CW = $clog2(BURST_LEN + 1);

  generate
    if (BURST_LEN < 1 || BURST_LEN > 512) begin : g_bad_burst
      $error("BURST_LEN out of range");
    end
    if (INIT_PAUSE_CYC < 1) begin : g_bad_pause
      $error("INIT_PAUSE_CYC must be at least one");
    end
    if (`SDC_MASK_LAT != 2) begin : g_bad_lat
      $error("Mask pipeline is built for a latency of two");
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // Command sampling

  sdc_pkg::sdc_cmd_t cmd_raw;
  sdc_pkg::sdc_cmd_t cmd;
  sdc_pkg::sdc_pwr_t pwr_r;
  sdc_pkg::sdc_pwr_t pwr_nxt;
  logic              take;
  logic              ap_req;

  sdc_cmd_decode u_dec (
    .pins_i (pins_i),
    .cmd_o  (cmd_raw)
  );

  // Commands count only while the internal clock runs
  assign take   = (pwr_r == sdc_pkg::SDC_PWR_ACTIVE) && cke_i;
  assign cmd    = take ? cmd_raw : sdc_pkg::SDC_NOP;
  assign ap_req = pins_i.addr[`SDC_AP_BIT];

  ////////////////////////////////////////////////////////////////////////////
  // Burst tracking

  logic                   rd_r,   rd_nxt;
  logic                   wr_r,   wr_nxt;
  logic [CW-1:0]          cnt_r,  cnt_nxt;
  logic                   ap_pend_r, ap_pend_nxt;
  logic [`SDC_BANK_W-1:0] ap_bank_r, ap_bank_nxt;
  logic                   ap_fire;
  logic [`SDC_BANK_W-1:0] ap_fire_bank;
  logic                   suspended;

  assign suspended = (pwr_r == sdc_pkg::SDC_PWR_SUSPEND);

  always_comb begin
    rd_nxt       = rd_r;
    wr_nxt       = wr_r;
    cnt_nxt      = cnt_r;
    ap_pend_nxt  = ap_pend_r;
    ap_bank_nxt  = ap_bank_r;
    ap_fire      = 1'b0;
    ap_fire_bank = ap_bank_r;
    if (!suspended) begin
      if (cnt_r == CW'(1)) begin
        cnt_nxt     = '0;
        rd_nxt      = 1'b0;
        wr_nxt      = 1'b0;
        ap_fire     = ap_pend_r;
        ap_pend_nxt = 1'b0;
      end else if (cnt_r != '0) begin
        cnt_nxt = cnt_r - CW'(1);
      end
      case (cmd)
        sdc_pkg::SDC_READ, sdc_pkg::SDC_WRITE: begin
          cnt_nxt     = CW'(BURST_LEN - 1);
          rd_nxt      = (cmd == sdc_pkg::SDC_READ) && (BURST_LEN > 1);
          wr_nxt      = (cmd == sdc_pkg::SDC_WRITE) && (BURST_LEN > 1);
          ap_bank_nxt = pins_i.bank_sel;
          ap_pend_nxt = ap_req && (BURST_LEN > 1);
          if (ap_req && BURST_LEN == 1) begin
            ap_fire      = 1'b1;
            ap_fire_bank = pins_i.bank_sel;
          end
        end
        sdc_pkg::SDC_BSTOP, sdc_pkg::SDC_PRECHARGE: begin
          cnt_nxt     = '0;
          rd_nxt      = 1'b0;
          wr_nxt      = 1'b0;
          ap_pend_nxt = 1'b0;
        end
        default: begin
        end
      endcase
    end
  end

  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      rd_r      <= 1'b0;
      wr_r      <= 1'b0;
      cnt_r     <= '0;
      ap_pend_r <= 1'b0;
      ap_bank_r <= '0;
    end else begin
      rd_r      <= rd_nxt;
      wr_r      <= wr_nxt;
      cnt_r     <= cnt_nxt;
      ap_pend_r <= ap_pend_nxt;
      ap_bank_r <= ap_bank_nxt;
    end
  end

  assign rd_busy_o = rd_r;
  assign wr_busy_o = wr_r;

  ////////////////////////////////////////////////////////////////////////////
  // Per-bank activity

  genvar b;
  generate
    for (b = 0; b < `SDC_NUM_BANKS; b++) begin : g_bank
      logic act_r, act_nxt;
      always_comb begin
        act_nxt = act_r;
        if (cmd == sdc_pkg::SDC_ACTIVATE && pins_i.bank_sel == b) begin
          act_nxt = 1'b1;
        end else if (cmd == sdc_pkg::SDC_PRECHARGE &&
                     (ap_req || pins_i.bank_sel == b)) begin
          act_nxt = 1'b0;
        end else if (ap_fire && ap_fire_bank == b) begin
          act_nxt = 1'b0;
        end
      end
      always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
          act_r <= 1'b0;
        end else begin
          act_r <= act_nxt;
        end
      end
      assign bank_active_o[b] = act_r;
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // Decoded operation and byte masks

  sdc_pkg::sdc_op_t      op_r, op_nxt;
  logic [`SDC_BYTES-1:0] mask_d1_r, oe_n_r, oe_n_nxt;

  always_comb begin
    op_nxt.cmd      = cmd;
    op_nxt.bank     = pins_i.bank_sel;
    op_nxt.row      = pins_i.addr;
    op_nxt.col      = pins_i.addr[`SDC_COL_W-1:0];
    op_nxt.auto_pre = ap_req && (cmd == sdc_pkg::SDC_READ ||
                                 cmd == sdc_pkg::SDC_WRITE);
    op_nxt.pre_all  = ap_req && (cmd == sdc_pkg::SDC_PRECHARGE);
    // Mask seen one edge ago floats the byte from the next edge on
    oe_n_nxt        = {`SDC_BYTES{~rd_r}} | mask_d1_r;
  end

  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      op_r      <= '{cmd: sdc_pkg::SDC_NOP, default: '0};
      mask_d1_r <= '0;
      oe_n_r    <= '1;
    end else begin
      op_r      <= op_nxt;
      mask_d1_r <= byte_mask_i;
      oe_n_r    <= oe_n_nxt;
    end
  end

  assign op_o      = op_r;
  assign dq_oe_n_o = oe_n_r;
  // Write lanes gated in the same cycle the mask is sampled
  assign wr_byte_en_o = {`SDC_BYTES{(cmd == sdc_pkg::SDC_WRITE) || (wr_r && !suspended)}}
                        & ~byte_mask_i;

  ////////////////////////////////////////////////////////////////////////////
  // Power states

  always_comb begin
    pwr_nxt = pwr_r;
    case (pwr_r)
      sdc_pkg::SDC_PWR_ACTIVE: begin
        if (!cke_i) begin
          if (cmd_raw == sdc_pkg::SDC_REFRESH) begin
            pwr_nxt = sdc_pkg::SDC_PWR_SELF_REF;
          end else if (rd_r || wr_r || (|bank_active_o)) begin
            pwr_nxt = sdc_pkg::SDC_PWR_SUSPEND;
          end else begin
            pwr_nxt = sdc_pkg::SDC_PWR_DOWN;
          end
        end
      end
      sdc_pkg::SDC_PWR_DOWN, sdc_pkg::SDC_PWR_SUSPEND, sdc_pkg::SDC_PWR_SELF_REF: begin
        if (cke_i) begin
          pwr_nxt = sdc_pkg::SDC_PWR_ACTIVE;
        end
      end
      default: pwr_nxt = sdc_pkg::SDC_PWR_ACTIVE;
    endcase
  end

  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      pwr_r <= sdc_pkg::SDC_PWR_ACTIVE;
    end else begin
      pwr_r <= pwr_nxt;
    end
  end

  assign pwr_state_o = pwr_r;

  ////////////////////////////////////////////////////////////////////////////
  // Mode register and initialization progress

  logic [`SDC_ROW_W-1:0] mode_r, mode_nxt;
  logic                  mvalid_r, mvalid_nxt;
  logic [31:0]           pause_r, pause_nxt;
  logic                  pre_seen_r, pre_seen_nxt;
  logic [3:0]            ref_r, ref_nxt;
  logic                  pause_done;

  assign pause_done = (pause_r >= INIT_PAUSE_CYC);

  always_comb begin
    mode_nxt     = mode_r;
    mvalid_nxt   = mvalid_r;
    pause_nxt    = pause_done ? pause_r : pause_r + 32'h1;
    pre_seen_nxt = pre_seen_r;
    ref_nxt      = ref_r;
    if (cmd == sdc_pkg::SDC_MRS) begin
      mode_nxt   = pins_i.addr;
      mvalid_nxt = 1'b1;
    end
    if (cmd == sdc_pkg::SDC_PRECHARGE && ap_req && pause_done) begin
      pre_seen_nxt = 1'b1;
    end
    if (cmd == sdc_pkg::SDC_REFRESH && pre_seen_r && ref_r != `SDC_INIT_REFRESH) begin
      ref_nxt = ref_r + 4'h1;
    end
  end

  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      mode_r     <= `SDC_MODE_RST;
      mvalid_r   <= 1'b0;
      pause_r    <= 32'h0;
      pre_seen_r <= 1'b0;
      ref_r      <= 4'h0;
    end else begin
      mode_r     <= mode_nxt;
      mvalid_r   <= mvalid_nxt;
      pause_r    <= pause_nxt;
      pre_seen_r <= pre_seen_nxt;
      ref_r      <= ref_nxt;
    end
  end

  assign mode_reg_o   = mode_r;
  assign mode_valid_o = mvalid_r;
  // Ready once pause, all-bank precharge, mode set and eight refreshes are seen
  assign init_done_o  = pre_seen_r && mvalid_r && (ref_r == `SDC_INIT_REFRESH);

  ////////////////////////////////////////////////////////////////////////////
  // Assertions

  property p_row_col;
    @(posedge clk_i) disable iff (reset_i)
      (take && cmd_raw == sdc_pkg::SDC_ACTIVATE) |=>
        (op_o.row == $past(pins_i.addr)) && (op_o.cmd == sdc_pkg::SDC_ACTIVATE);
  endproperty
  a_row_col: assert property (p_row_col) else $error("Row not captured");

  property p_pre_all;
    @(posedge clk_i) disable iff (reset_i)
      (take && cmd_raw == sdc_pkg::SDC_PRECHARGE && ap_req) |=> (bank_active_o == '0);
  endproperty
  a_pre_all: assert property (p_pre_all) else $error("Banks open after precharge all");

  property p_bank_sel;
    @(posedge clk_i) disable iff (reset_i)
      (take && cmd_raw == sdc_pkg::SDC_ACTIVATE) |=>
        bank_active_o[op_o.bank] && (op_o.bank == $past(pins_i.bank_sel));
  endproperty
  a_bank_sel: assert property (p_bank_sel) else $error("Wrong bank opened");

  property p_deselect;
    @(posedge clk_i) disable iff (reset_i)
      pins_i.cs_n |=> (op_o.cmd inside {sdc_pkg::SDC_DESEL, sdc_pkg::SDC_NOP}) &&
                      (mode_reg_o == $past(mode_reg_o));
  endproperty
  a_deselect: assert property (p_deselect) else $error("Command taken while deselected");

  property p_read_dec;
    @(posedge clk_i) disable iff (reset_i)
      (take && !pins_i.cs_n && pins_i.ras_n && !pins_i.cas_n && pins_i.we_n) |=>
        (op_o.cmd == sdc_pkg::SDC_READ) && !wr_busy_o;
  endproperty
  a_read_dec: assert property (p_read_dec) else $error("Read not decoded");

  property p_rd_mask;
    @(posedge clk_i) disable iff (reset_i)
      ($past(!reset_i, 2) && $past(byte_mask_i[0], 2)) |-> dq_oe_n_o[0];
  endproperty
  a_rd_mask: assert property (p_rd_mask) else $error("Masked byte driven");

  property p_wr_mask;
    @(posedge clk_i) disable iff (reset_i)
      (take && cmd_raw == sdc_pkg::SDC_WRITE) |-> (wr_byte_en_o == ~byte_mask_i);
  endproperty
  a_wr_mask: assert property (p_wr_mask) else $error("Write lanes not masked");

  property p_cke_low;
    @(posedge clk_i) disable iff (reset_i)
      (pwr_state_o == sdc_pkg::SDC_PWR_ACTIVE && !cke_i) |=>
        ((pwr_state_o != sdc_pkg::SDC_PWR_ACTIVE) && (op_o.cmd == sdc_pkg::SDC_NOP))
        ##1 (op_o.cmd == sdc_pkg::SDC_NOP);
  endproperty
  a_cke_low: assert property (p_cke_low) else $error("Clock enable low ignored");

  property p_mode_set;
    @(posedge clk_i) disable iff (reset_i)
      $rose(mode_valid_o) |-> $past(take && cmd_raw == sdc_pkg::SDC_MRS) &&
                              (mode_reg_o == $past(pins_i.addr));
  endproperty
  a_mode_set: assert property (p_mode_set) else $error("Mode register not loaded");

  property p_bstop;
    @(posedge clk_i) disable iff (reset_i)
      (take && cmd_raw == sdc_pkg::SDC_BSTOP) |=> !rd_busy_o && !wr_busy_o;
  endproperty
  a_bstop: assert property (p_bstop) else $error("Burst not stopped");

endmodule // sdc_front

// ---- sdc_ctrl_model.sv ----
// Purpose: Memory controller stand-in that drives the command front end
// Assumes: Pins change just after a rising clock edge
// Notes:   Timing gaps are cycle counts kept short for simulation
`timescale 1ns/1ps
`include "sdc_defs.svh"

module sdc_ctrl_model #(
  parameter int unsigned PAUSE_CYC           = 12,
  parameter int unsigned ROW_TO_COLUMN_DELAY = 2,
  parameter int unsigned ROW_CYCLE_TIME      = 3,
  parameter int unsigned BANK_TO_BANK_GAP    = 2,
  parameter int unsigned ROW_ACTIVE_WINDOW   = 1000,
  parameter int unsigned MODE_SET_GAP        = 2
) (
  input  wire logic             clk_i,
  output logic                  cke_o,
  output sdc_pkg::sdc_pins_t    pins_o,
  output logic [`SDC_BYTES-1:0] byte_mask_o
);
  // Padding must close every bank well inside the active window
  generate
    if (ROW_ACTIVE_WINDOW <= ROW_TO_COLUMN_DELAY + BANK_TO_BANK_GAP + ROW_CYCLE_TIME)
    begin : g_bad_window
      $error("Row active window shorter than the command padding");
    end
  endgenerate
  ////////////////////////////////////////
  initial begin
    cke_o       = 1'b1;
    pins_o      = 17'h0e000;
    byte_mask_o = 4'hf;
  end

  // Select, row strobe, column strobe, write select
  function automatic sdc_pkg::sdc_pins_t enc(input sdc_pkg::sdc_cmd_t c,
                                             input logic [1:0] b, input logic [10:0] a);
    logic [3:0] s;
    case (c)
      sdc_pkg::SDC_DESEL:     s = 4'hb; // Activate pattern, select off
      sdc_pkg::SDC_MRS:       s = 4'h0;
      sdc_pkg::SDC_REFRESH:   s = 4'h1;
      sdc_pkg::SDC_PRECHARGE: s = 4'h2;
      sdc_pkg::SDC_ACTIVATE:  s = 4'h3;
      sdc_pkg::SDC_WRITE:     s = 4'h4;
      sdc_pkg::SDC_READ:      s = 4'h5;
      sdc_pkg::SDC_BSTOP:     s = 4'h6;
      default:                s = 4'h7;
    endcase
    return {s, b, a};
  endfunction

  task automatic step(input sdc_pkg::sdc_cmd_t c, input logic [1:0] b,
                      input logic [10:0] a, input logic [3:0] m, input logic k);
    @(posedge clk_i);
    pins_o      <= enc(c, b, a);
    byte_mask_o <= m;
    cke_o       <= k;
  endtask

  // Command for one edge, then back to no-operation
  task automatic send(input sdc_pkg::sdc_cmd_t c, input logic [1:0] b,
                      input logic [10:0] a, input logic [3:0] m, input logic k);
    step(c, b, a, m, k);
    step(sdc_pkg::SDC_NOP, 2'h0, 11'h000, m, k);
  endtask

  // Idle cycles owed after a command; banks close long before the active window
  task automatic pad(input sdc_pkg::sdc_cmd_t c);
    int unsigned n;
    case (c)
      sdc_pkg::SDC_ACTIVATE: n = ROW_TO_COLUMN_DELAY + BANK_TO_BANK_GAP;
      sdc_pkg::SDC_PRECHARGE,
      sdc_pkg::SDC_REFRESH:  n = ROW_CYCLE_TIME;
      sdc_pkg::SDC_MRS:      n = MODE_SET_GAP;
      default:               n = 0;
    endcase
    repeat (n) step(sdc_pkg::SDC_NOP, 2'h0, 11'h000, 4'h0, 1'b1);
  endtask

  task automatic init_seq(input logic [10:0] mode);
    repeat (PAUSE_CYC) step(sdc_pkg::SDC_NOP, 2'h0, 11'h000, 4'hf, 1'b1);
    send(sdc_pkg::SDC_PRECHARGE, 2'h0, 11'h400, 4'hf, 1'b1);
    pad(sdc_pkg::SDC_PRECHARGE);
    repeat (8) begin
      send(sdc_pkg::SDC_REFRESH, 2'h0, 11'h000, 4'h0, 1'b1);
      pad(sdc_pkg::SDC_REFRESH);
    end
    send(sdc_pkg::SDC_MRS, 2'h0, mode, 4'h0, 1'b1);
    pad(sdc_pkg::SDC_MRS);
  endtask
endmodule // sdc_ctrl_model

// ---- sdram_command_init_activate_test.sv ----
// Purpose: Self-checking bench for the command front end
// Assumes: Controller model drives every pin
// Notes:   Pause shortened to 10 cycles
`timescale 1ns/1ps
`include "sdc_defs.svh"

module sdram_command_init_activate_test;
  logic                  clk_i;
  logic                  reset_i;
  logic                  cke;
  sdc_pkg::sdc_pins_t    pins;
  logic [3:0]            mask;
  sdc_pkg::sdc_op_t      op;
  logic [3:0]            act;
  logic [10:0]           mode;
  logic                  mode_ok;
  sdc_pkg::sdc_pwr_t     pwr;
  logic                  rd_busy;
  logic                  wr_busy;
  logic [3:0]            oe_n;
  logic [3:0]            wr_en;
  logic                  init_done;
  int                    fails;
  int                    n_checks;

  sdc_front #(.BURST_LEN(4), .INIT_PAUSE_CYC(10)) dut_u (
    .clk_i(clk_i), .reset_i(reset_i), .cke_i(cke), .pins_i(pins),
    .byte_mask_i(mask), .op_o(op), .bank_active_o(act), .mode_reg_o(mode),
    .mode_valid_o(mode_ok), .pwr_state_o(pwr), .rd_busy_o(rd_busy),
    .wr_busy_o(wr_busy), .dq_oe_n_o(oe_n), .wr_byte_en_o(wr_en),
    .init_done_o(init_done));

  sdc_ctrl_model ctl_u (.clk_i(clk_i), .cke_o(cke), .pins_o(pins), .byte_mask_o(mask));

  ////////////////////////////////////////
  initial begin
    clk_i = 1'b0;
    forever #20 clk_i = ~clk_i;
  end

  task automatic check(input logic [15:0] seen, input logic [15:0] want);
    n_checks++;
    if (seen !== want) begin
      fails++;
      $display("wrong value at %0t: saw %h, expected %h", $time, seen, want);
    end
  endtask

  task automatic t_init;
    ctl_u.init_seq(11'h123);
    @(negedge clk_i);
    check(mode, 11'h123);
    check(mode_ok, 1'b1);
    check(init_done, 1'b1);
    check(act, 4'h0);
  endtask

  task automatic t_bank;
    ctl_u.send(sdc_pkg::SDC_ACTIVATE, 2'h2, 11'h5a5, 4'h0, 1'b1);
    @(negedge clk_i);
    check(op.cmd, sdc_pkg::SDC_ACTIVATE);
    check(op.row, 11'h5a5);
    check(op.bank, 2'h2);
    check(act, 4'h4);
    ctl_u.pad(sdc_pkg::SDC_ACTIVATE);
    ctl_u.send(sdc_pkg::SDC_DESEL, 2'h3, 11'h000, 4'h0, 1'b1);
    @(negedge clk_i);
    check(op.cmd, sdc_pkg::SDC_DESEL);
    check(act, 4'h4);
    ctl_u.send(sdc_pkg::SDC_ACTIVATE, 2'h3, 11'h0ff, 4'h0, 1'b1);
    ctl_u.pad(sdc_pkg::SDC_ACTIVATE);
    ctl_u.send(sdc_pkg::SDC_PRECHARGE, 2'h2, 11'h000, 4'h0, 1'b1);
    @(negedge clk_i);
    check(op.pre_all, 1'b0);
    check(act, 4'h8);
    ctl_u.pad(sdc_pkg::SDC_PRECHARGE);
    ctl_u.send(sdc_pkg::SDC_PRECHARGE, 2'h0, 11'h400, 4'h0, 1'b1);
    @(negedge clk_i);
    check(op.pre_all, 1'b1);
    check(act, 4'h0);
    ctl_u.pad(sdc_pkg::SDC_PRECHARGE);
  endtask

  task automatic t_write;
    int k;
    ctl_u.send(sdc_pkg::SDC_ACTIVATE, 2'h1, 11'h0aa, 4'h0, 1'b1);
    ctl_u.pad(sdc_pkg::SDC_ACTIVATE);
    fork
      ctl_u.send(sdc_pkg::SDC_WRITE, 2'h1, 11'h43c, 4'h5, 1'b1);
      begin
        @(posedge clk_i);
        @(negedge clk_i);
        check(wr_en, 4'ha);
      end
    join
    @(negedge clk_i);
    check(op.cmd, sdc_pkg::SDC_WRITE);
    check(op.col, 8'h3c);
    check(op.auto_pre, 1'b1);
    check(wr_busy, 1'b1);
    k = 0;
    while (act[1] === 1'b1 && k < 8) begin
      @(negedge clk_i);
      k++;
    end
    check(k[15:0], 16'h0003);
  endtask

  task automatic t_read;
    ctl_u.send(sdc_pkg::SDC_ACTIVATE, 2'h0, 11'h011, 4'h0, 1'b1);
    ctl_u.pad(sdc_pkg::SDC_ACTIVATE);
    ctl_u.step(sdc_pkg::SDC_READ, 2'h0, 11'h010, 4'h0, 1'b1);
    ctl_u.step(sdc_pkg::SDC_DESEL, 2'h0, 11'h000, 4'h0, 1'b1);
    @(negedge clk_i);
    check(op.cmd, sdc_pkg::SDC_READ);
    ctl_u.step(sdc_pkg::SDC_NOP, 2'h0, 11'h000, 4'h1, 1'b1);
    @(negedge clk_i);
    check(rd_busy, 1'b1);
    for (int i = 0; i < 3; i++) begin
      ctl_u.step(sdc_pkg::SDC_NOP, 2'h0, 11'h000, 4'h0, 1'b1);
      @(negedge clk_i);
      check(oe_n, (i == 0) ? 4'h0 : ((i == 1) ? 4'h1 : 4'hf));
    end
    ctl_u.send(sdc_pkg::SDC_PRECHARGE, 2'h0, 11'h400, 4'h0, 1'b1);
    ctl_u.pad(sdc_pkg::SDC_PRECHARGE);
  endtask

  task automatic t_power;
    ctl_u.send(sdc_pkg::SDC_NOP, 2'h0, 11'h000, 4'h0, 1'b0);
    @(negedge clk_i);
    check(pwr, sdc_pkg::SDC_PWR_DOWN);
    ctl_u.send(sdc_pkg::SDC_ACTIVATE, 2'h0, 11'h000, 4'h0, 1'b0);
    @(negedge clk_i);
    check(op.cmd, sdc_pkg::SDC_NOP);
    check(act, 4'h0);
    ctl_u.send(sdc_pkg::SDC_NOP, 2'h0, 11'h000, 4'h0, 1'b1);
    @(negedge clk_i);
    check(pwr, sdc_pkg::SDC_PWR_ACTIVE);
    ctl_u.send(sdc_pkg::SDC_REFRESH, 2'h0, 11'h000, 4'h0, 1'b0);
    @(negedge clk_i);
    check(pwr, sdc_pkg::SDC_PWR_SELF_REF);
    ctl_u.send(sdc_pkg::SDC_NOP, 2'h0, 11'h000, 4'h0, 1'b1);
    ctl_u.pad(sdc_pkg::SDC_REFRESH);
    ctl_u.send(sdc_pkg::SDC_ACTIVATE, 2'h1, 11'h001, 4'h0, 1'b1);
    ctl_u.pad(sdc_pkg::SDC_ACTIVATE);
    ctl_u.send(sdc_pkg::SDC_NOP, 2'h0, 11'h000, 4'h0, 1'b0);
    @(negedge clk_i);
    check(pwr, sdc_pkg::SDC_PWR_SUSPEND);
    ctl_u.send(sdc_pkg::SDC_NOP, 2'h0, 11'h000, 4'h0, 1'b1);
    @(negedge clk_i);
    check(pwr, sdc_pkg::SDC_PWR_ACTIVE);
    ctl_u.send(sdc_pkg::SDC_PRECHARGE, 2'h0, 11'h400, 4'h0, 1'b1);
    ctl_u.pad(sdc_pkg::SDC_PRECHARGE);
  endtask

  task automatic t_decode;
    sdc_pkg::sdc_cmd_t list [4];
    list = '{sdc_pkg::SDC_NOP, sdc_pkg::SDC_REFRESH, sdc_pkg::SDC_MRS, sdc_pkg::SDC_BSTOP};
    foreach (list[i]) begin
      ctl_u.send(list[i], 2'h0, 11'h2a5, 4'h0, 1'b1);
      @(negedge clk_i);
      check(op.cmd, list[i]);
      ctl_u.pad(list[i]);
    end
    check(mode, 11'h2a5);
  endtask

  task automatic print_verdict;
    $display("checks %0d, mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  initial begin
    fails    = 0;
    n_checks = 0;
    reset_i  = 1'b1;
    repeat (2) @(posedge clk_i);
    reset_i <= 1'b0;
    @(negedge clk_i);
    check(op.cmd, sdc_pkg::SDC_NOP);
    check(act, 4'h0);
    check(mode_ok, 1'b0);
    check(oe_n, 4'hf);
    check(init_done, 1'b0);
    t_init;
    t_bank;
    t_write;
    t_read;
    t_power;
    t_decode;
    print_verdict;
  end
endmodule // sdram_command_init_activate_test
